// ==== pcc_pkg.sv ====
// Package of constants for the companding coder and decoder
package pcc_pkg;
  // ----------------------------------------------------------------------
  // Sample and code widths
  // ----------------------------------------------------------------------
  localparam int LIN_W = 13;
  localparam int CODE_W = 8;
  localparam int CHORD_W = 3;
  localparam int STEP_W = 4;
  localparam int SIGN_POS = 7;
  localparam int CHORD_LSB = 4;
  localparam int STEP_LSB = 0;
  // ----------------------------------------------------------------------
  // Law coding constants
  // ----------------------------------------------------------------------
  localparam logic [12:0] MU_BIAS = 13'h0021;
  localparam logic [12:0] MU_CLIP = 13'h0fdf;
  localparam logic [7:0] MU_INV = 8'hff;
  localparam logic [7:0] A_INV = 8'h55;
  localparam logic LAW_MU = 1'b1;
  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int CLK_HZ = 200_000_000;
  localparam int SAMPLE_HZ = 8_000;
  localparam int SAMPLE_CYC = CLK_HZ / SAMPLE_HZ;
  localparam int FIFO_DEPTH = 16;
  localparam int SYNC_STAGES = 3;
endpackage

// ==== pcc_fifo.sv ====
// Flip-flop FIFO with valid/ready on both sides
`timescale 1ns/100ps
module pcc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic srst_i,
  // Fill side
  input wire logic in_valid_i,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic in_ready_o,
  // Drain side
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
  logic [AW:0] cnt_q, cnt_d;
  logic push, pop;

  // ----------------------------------------------------------------------
  // Pointer and count update
  // ----------------------------------------------------------------------
  always_comb begin
    push = in_valid_i && (cnt_q != (AW+1)'(DEPTH));
    pop = out_ready_i && (cnt_q != '0);
    wr_d = push ? wr_q + 1'b1 : wr_q;
    rd_d = pop ? rd_q + 1'b1 : rd_q;
    cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
  end

  // Storage has no reset; only the pointers and count need defined state
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      wr_q <= wr_d;
      rd_q <= rd_d;
      cnt_q <= cnt_d;
    end
    if (push) mem_q[wr_q] <= in_data_i;
  end

  assign in_ready_o = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid_o = (cnt_q != '0);
  assign out_data_o = mem_q[rd_q];
endmodule // pcc_fifo

// ==== pcc_codec.sv ====
// Companding encoder and decoder with frame-synced serial transmit
`timescale 1ns/100ps
module pcc_codec
  import pcc_pkg::*;
#(
  parameter int SAMPLE_CYCLES = SAMPLE_CYC
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic srst_i,
  // Law strap pin
  input wire logic law_select_i,
  // Converter side: linear sample in, linear value out
  input wire logic [LIN_W-1:0] adc_sample_i,
  output logic [LIN_W-1:0] dac_sample_o,
  output logic dac_strobe_o,
  // Serial highway side
  input wire logic tx_frame_sync_i,
  input wire logic bit_clk_i,
  output logic tx_serial_out_o,
  output logic tx_serial_oe_n_o,
  input wire logic rx_serial_in_i,
  // Status
  output logic tx_overrun_o
);
  typedef enum logic {TX_IDLE, TX_SHIFT} pcc_tx_e;

  // ----------------------------------------------------------------------
  // Law functions
  // ----------------------------------------------------------------------
  // Position of highest set bit among 8 chord-select bits
  function automatic logic [2:0] chord_of(input logic [7:0] v);
    logic [2:0] c;
    c = 3'h0;
    for (int i = 1; i < 8; i++) if (v[i]) c = 3'(i);
    return c;
  endfunction

  // Compress 13-bit two's complement sample
  function automatic logic [7:0] compress(input logic [12:0] s,
                                          input logic mu);
    logic [12:0] mag;
    logic [2:0] ch;
    logic [3:0] st;
    logic [7:0] code;
    mag = s[12] ? 13'(~s + 13'h0001) : s;
    if (mu) begin
      // Mu curve runs on twice the sample so all eight chords are reached
      if (mag > MU_CLIP) mag = MU_CLIP;
      mag = 13'({mag[11:0], 1'b0}) + MU_BIAS;
      ch = chord_of(mag[12:5]);
      st = 4'(mag >> (4'(ch) + 4'h1));
      // Positive codes keep bit 7 high once inverted
      code = {s[12], ch, st} ^ MU_INV;
    end else begin
      if (mag > 13'h0fff) mag = 13'h0fff;
      ch = chord_of({mag[11:5], 1'b0});
      st = (ch == 3'h0) ? 4'(mag >> 1) : 4'(mag >> ch);
      code = {~s[12], ch, st} ^ A_INV;
    end
    // Sign, chord, step layout step carries to chord
    return code;
  endfunction

  // Expand code to 13-bit linear value
  function automatic logic [12:0] expand(input logic [7:0] c,
                                         input logic mu);
    logic [7:0] u;
    logic [12:0] mag;
    u = c ^ (mu ? MU_INV : A_INV);
    if (mu) begin
      // Equal step weight within chord, doubling per chord
      mag = 13'((13'({u[3:0], 1'b1}) + 13'h0020) << u[6:4]);
      mag = (mag - MU_BIAS) >> 1;
    end else if (u[6:4] == 3'h0) begin
      mag = 13'({u[3:0], 1'b1});
    end else begin
      mag = 13'((13'({1'b1, u[3:0], 1'b1})) << (u[6:4] - 3'h1));
    end
    // Sign bit sense differs between the two laws
    return (u[SIGN_POS] ^ mu) ? mag : 13'(~mag + 13'h0001);
  endfunction

  // ----------------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------------
  logic [2:0] fs_sync_q, bc_sync_q, rx_sync_q, law_sync_q;
  logic fs_lvl_q, bc_lvl_q, fs_rise, bc_rise, bc_fall;
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      fs_sync_q <= '0;
      bc_sync_q <= '0;
      rx_sync_q <= '0;
      law_sync_q <= {3{LAW_MU}};
      fs_lvl_q <= 1'b0;
      bc_lvl_q <= 1'b0;
    end else begin
      fs_sync_q <= {fs_sync_q[1:0], tx_frame_sync_i};
      bc_sync_q <= {bc_sync_q[1:0], bit_clk_i};
      rx_sync_q <= {rx_sync_q[1:0], rx_serial_in_i};
      law_sync_q <= {law_sync_q[1:0], law_select_i};
      // Level updates only when stages two and three agree
      if (fs_sync_q[1] == fs_sync_q[2]) fs_lvl_q <= fs_sync_q[2];
      if (bc_sync_q[1] == bc_sync_q[2]) bc_lvl_q <= bc_sync_q[2];
    end
  end
  assign fs_rise = (fs_sync_q[1] == fs_sync_q[2]) && fs_sync_q[2]
                   && !fs_lvl_q;
  assign bc_rise = (bc_sync_q[1] == bc_sync_q[2]) && bc_sync_q[2]
                   && !bc_lvl_q;
  assign bc_fall = (bc_sync_q[1] == bc_sync_q[2]) && !bc_sync_q[2]
                   && bc_lvl_q;

  // ----------------------------------------------------------------------
  // Sample timer and encoder into FIFO
  // ----------------------------------------------------------------------
  logic [$clog2(SAMPLE_CYCLES)-1:0] tmr_q, tmr_d;
  logic law_q, law_d, enc_vld_q, enc_vld_d, ovr_q, ovr_d;
  logic [7:0] enc_q, enc_d;
  logic fifo_rdy, fifo_vld, fifo_pop;
  logic [7:0] fifo_dat;
  logic tick;

  // One encode per sample period
  always_comb begin
    tick = (tmr_q == '0);
    tmr_d = tick ? ($bits(tmr_q))'(SAMPLE_CYCLES - 1) : tmr_q - 1'b1;
    // Strap pin is asynchronous; take it once stages two and three agree
    law_d = (law_sync_q[1] == law_sync_q[2]) ? law_sync_q[2] : law_q;
    enc_d = tick ? compress(adc_sample_i, law_q) : enc_q;
    enc_vld_d = tick ? 1'b1 : (enc_vld_q && !fifo_rdy);
    // Sticky overrun when the highway drains slower than the sample rate
    ovr_d = ovr_q || (tick && enc_vld_q && !fifo_rdy);
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      tmr_q <= '0;
      law_q <= LAW_MU;
      enc_q <= '0;
      enc_vld_q <= 1'b0;
      ovr_q <= 1'b0;
    end else begin
      tmr_q <= tmr_d;
      law_q <= law_d;
      enc_q <= enc_d;
      enc_vld_q <= enc_vld_d;
      ovr_q <= ovr_d;
    end
  end

  pcc_fifo #(.WIDTH(CODE_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .mclk_i(mclk_i),
    .srst_i(srst_i),
    .in_valid_i(enc_vld_q),
    .in_data_i(enc_q),
    .in_ready_o(fifo_rdy),
    .out_valid_o(fifo_vld),
    .out_ready_i(fifo_pop),
    .out_data_o(fifo_dat)
  );

  // ----------------------------------------------------------------------
  // Serial transmit and receive, framed by sync
  // ----------------------------------------------------------------------
  pcc_tx_e st_q, st_d;
  logic [7:0] sh_q, sh_d, rsh_q, rsh_d, rcode_q, rcode_d;
  logic [3:0] bit_q, bit_d;
  logic dout_q, dout_d, oe_n_q, oe_n_d, dstb_q, dstb_d;
  logic [12:0] dac_q, dac_d;

  always_comb begin
    st_d = st_q;
    sh_d = sh_q;
    bit_d = bit_q;
    rsh_d = rsh_q;
    rcode_d = rcode_q;
    dout_d = dout_q;
    oe_n_d = oe_n_q;
    dstb_d = 1'b0;
    dac_d = dac_q;
    fifo_pop = 1'b0;
    unique case (st_q)
      TX_IDLE: begin
        // Frame starts on sync; sends the queued code, or 8'hff if the queue is empty
        if (fs_rise) begin
          st_d = TX_SHIFT;
          bit_d = 4'h0;
          sh_d = fifo_vld ? fifo_dat : 8'hff;
          fifo_pop = fifo_vld;
        end
      end
      TX_SHIFT: begin
        if (bc_rise) begin
          dout_d = sh_q[7];
          oe_n_d = 1'b0;
          sh_d = {sh_q[6:0], 1'b0};
        end
        if (bc_fall) begin
          rsh_d = {rsh_q[6:0], rx_sync_q[2]};
          bit_d = bit_q + 4'h1;
          if (bit_q == 4'h7) begin
            // One received code per frame, expanded
            rcode_d = {rsh_q[6:0], rx_sync_q[2]};
            dac_d = expand({rsh_q[6:0], rx_sync_q[2]}, law_q);
            dstb_d = 1'b1;
            oe_n_d = 1'b1;
            st_d = TX_IDLE;
          end
        end
      end
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      st_q <= TX_IDLE;
      sh_q <= '0;
      bit_q <= '0;
      rsh_q <= '0;
      rcode_q <= '0;
      dout_q <= 1'b0;
      oe_n_q <= 1'b1;
      dstb_q <= 1'b0;
      dac_q <= '0;
    end else begin
      st_q <= st_d;
      sh_q <= sh_d;
      bit_q <= bit_d;
      rsh_q <= rsh_d;
      rcode_q <= rcode_d;
      dout_q <= dout_d;
      oe_n_q <= oe_n_d;
      dstb_q <= dstb_d;
      dac_q <= dac_d;
    end
  end

  assign tx_serial_out_o = dout_q;
  assign tx_serial_oe_n_o = oe_n_q;
  assign dac_sample_o = dac_q;
  assign dac_strobe_o = dstb_q;
  assign tx_overrun_o = ovr_q;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  sequence s_tick;
    tmr_q == '0;
  endsequence
  a_tick_period: assert property (@(posedge mclk_i)
    disable iff (srst_i) s_tick |=> !tick [*2])
    else $error("sample tick repeated too soon");
  a_enc_law: assert property (@(posedge mclk_i)
    disable iff (srst_i)
    tick |=> enc_q == compress($past(adc_sample_i), $past(law_q)))
    else $error("encoder output mismatch");
  a_mu_zero: assert property (@(posedge mclk_i)
    disable iff (srst_i)
    (tick && law_q && adc_sample_i == '0) |=> enc_q == 8'hff)
    else $error("mu zero code wrong");
  a_a_zero: assert property (@(posedge mclk_i)
    disable iff (srst_i)
    (tick && !law_q && adc_sample_i == '0) |=> enc_q == 8'hd5)
    else $error("a-law zero code wrong");
  a_dec_round: assert property (@(posedge mclk_i)
    disable iff (srst_i) dstb_q |-> compress(dac_q, law_q) == rcode_q)
    else $error("decode does not round trip");
  a_chord_double: assert property (@(posedge mclk_i)
    disable iff (srst_i)
    (tick && law_q && adc_sample_i == 13'h0100)
    |=> (enc_q[6:4] ^ MU_INV[6:4]) == 3'h4)
    else $error("chord weighting wrong");
  a_step_carry: assert property (@(posedge mclk_i)
    disable iff (srst_i)
    (tick && !law_q && adc_sample_i == 13'h0020) |=> enc_q == 8'hc5)
    else $error("step carry wrong");
  a_frame_code: assert property (@(posedge mclk_i)
    disable iff (srst_i)
    (st_q == TX_IDLE && fs_rise) |=> st_q == TX_SHIFT)
    else $error("frame did not start on sync");
  a_oe_quiet: assert property (@(posedge mclk_i)
    disable iff (srst_i)
    st_q == TX_IDLE && $past(st_q) == TX_IDLE |-> oe_n_q)
    else $error("serial driven outside frame");
  a_dec_code: assert property (@(posedge mclk_i)
    disable iff (srst_i)
    dstb_q |-> $past(st_q) == TX_SHIFT && $past(bit_q) == 4'h7)
    else $error("decode strobe without full code");
endmodule // pcc_codec

// ==== pcc_highway_model.sv ====
// Serial highway model: frame sync, bit clock, receive data, capture
`timescale 1ns/100ps
module pcc_highway_model #(
  parameter int HALF_BIT = 8
) (
  // Clock
  input wire logic mclk_i,
  // From the codec
  input wire logic tx_serial_out_i,
  input wire logic tx_serial_oe_n_i,
  // To the codec
  output logic tx_frame_sync_o,
  output logic bit_clk_o,
  output logic rx_serial_o,
  // Captured code
  output logic [7:0] tx_code_o,
  output logic tx_done_o,
  output logic oe_bad_o
);
  // Clocks stand still low between frames
  initial begin
    tx_frame_sync_o = 1'b0;
    bit_clk_o = 1'b0;
    rx_serial_o = 1'b0;
    tx_code_o = 8'h00;
    tx_done_o = 1'b0;
    oe_bad_o = 1'b0;
  end
  // One frame: sync rise, then eight bits MSB first
  task automatic frame(input logic [7:0] rx_code);
    @(posedge mclk_i);
    tx_frame_sync_o <= 1'b1;
    repeat (HALF_BIT) @(posedge mclk_i);
    for (int i = 7; i >= 0; i--) begin
      tx_frame_sync_o <= 1'b0;
      bit_clk_o <= 1'b1;
      rx_serial_o <= rx_code[i];
      repeat (HALF_BIT) @(posedge mclk_i);
      tx_code_o[i] <= tx_serial_out_i;
      if (tx_serial_oe_n_i !== 1'b0) oe_bad_o <= 1'b1;
      bit_clk_o <= 1'b0;
      repeat (HALF_BIT) @(posedge mclk_i);
    end
    // Released line flips so a stale bit cannot pass
    rx_serial_o <= ~rx_code[0];
    tx_done_o <= 1'b1;
    @(posedge mclk_i);
    tx_done_o <= 1'b0;
  endtask
endmodule // pcc_highway_model

// ==== testbench.sv ====
// Self-checking testbench for the companding codec
`timescale 1ns/100ps
module testbench;
  import pcc_pkg::*;
  // ----------------------------------------------------------------
  // Signals; period leaves room for two frames
  // ----------------------------------------------------------------
  localparam int P = 320;
  localparam int NONE = 99999;
  logic mclk_i = 1'b0;
  logic srst_i = 1'b1;
  logic law_select_i = LAW_MU;
  logic [LIN_W-1:0] adc_sample_i = '0;
  logic [LIN_W-1:0] dac_sample_o;
  logic dac_strobe_o, tx_frame_sync_i, bit_clk_i, tx_serial_out_o;
  logic tx_serial_oe_n_o, rx_serial_in_i, tx_overrun_o, tx_done, oe_bad;
  logic [7:0] tx_code, last;
  int fail_count = 0;
  int checks = 0;
  int cyc = 0;
  int r0, c, h1, h2, h3, k;
  int exp_dac[$];
  int exp_tx[$];
  always #2.5 mclk_i = ~mclk_i;
  always @(posedge mclk_i) cyc <= cyc + 1;
  pcc_codec #(.SAMPLE_CYCLES(P)) i_pcc_codec (.mclk_i(mclk_i),
    .srst_i(srst_i), .law_select_i(law_select_i),
    .adc_sample_i(adc_sample_i), .dac_sample_o(dac_sample_o),
    .dac_strobe_o(dac_strobe_o), .tx_frame_sync_i(tx_frame_sync_i),
    .bit_clk_i(bit_clk_i), .tx_serial_out_o(tx_serial_out_o),
    .tx_serial_oe_n_o(tx_serial_oe_n_o), .rx_serial_in_i(rx_serial_in_i),
    .tx_overrun_o(tx_overrun_o));
  pcc_highway_model i_pcc_highway_model (.mclk_i(mclk_i),
    .tx_serial_out_i(tx_serial_out_o), .tx_serial_oe_n_i(tx_serial_oe_n_o),
    .tx_frame_sync_o(tx_frame_sync_i), .bit_clk_o(bit_clk_i),
    .rx_serial_o(rx_serial_in_i), .tx_code_o(tx_code), .tx_done_o(tx_done),
    .oe_bad_o(oe_bad));
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [12:0] seen, input logic [12:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Loose bound: step weight doubles per chord, so error tracks size
  function automatic logic [12:0] near(input logic [12:0] v, input int x);
    int d;
    d = int'($signed(v)) - x;
    d = d < 0 ? -d : d;
    return {12'h000, d <= (x < 0 ? -x : x) / 8 + 4};
  endfunction
  // Step to four cycles after the next encode tick
  task automatic wait_slot();
    k++;
    for (int n = 0; cyc < r0 + k * P + 5; n++) begin
      if (n > 2 * P) begin
        fail_count++;
        complete_run();
      end
      @(posedge mclk_i);
    end
  endtask
  // Mode 0 random, 1 sweep, 2 two extra frames, last empty, 3 no frame
  task automatic period(input logic law, input int mode);
    int x;
    logic [7:0] prev, inv;
    wait_slot();
    inv = law ? MU_INV : A_INV;
    if (law !== law_select_i) c = 0;
    x = int'($urandom_range(7998)) - 3999;
    // Sweep hits zero, then doubles so each chord is crossed
    if (mode == 1 && c < 10) x = (c == 0) ? 0 : 4 << c;
    law_select_i <= law;
    adc_sample_i <= 13'(x);
    if (mode != 3) begin
      exp_tx.push_back(-1);
      // Two queued codes plus the loopback: decode shows x three back
      exp_dac.push_back(c >= 3 ? h3 : NONE);
      prev = last;
      i_pcc_highway_model.frame(last);
      last = tx_code;
      prev = prev ^ inv;
      inv = last ^ inv;
      if (mode == 1 && c >= 3 && c <= 10) begin
        check({12'h000, inv[6:0] > prev[6:0]}, 13'h0001);
        check({12'h000, inv[6:4] - prev[6:4] <= 3'h1}, 13'h0001);
        check({12'h000, inv[7] ^ prev[7]}, 13'h0000);
      end
    end
    // Second frame drains the queue, third finds it empty
    if (mode == 2) begin
      for (int f = 0; f < 2; f++) begin
        exp_tx.push_back(f == 0 ? -1 : int'(8'hff));
        exp_dac.push_back(-31);
        i_pcc_highway_model.frame(8'h5a);
      end
    end
    h3 = h2;
    h2 = h1;
    h1 = x;
    c++;
  endtask
  // ----------------------------------------------------------------
  // Watchers match results to the oldest note
  // ----------------------------------------------------------------
  always @(posedge mclk_i) begin
    if (tx_done === 1'b1) begin
      if (exp_tx.size() == 0) check(13'h0000, 13'h0001);
      else if (exp_tx[0] < 0) void'(exp_tx.pop_front());
      else check(13'(tx_code), 13'(exp_tx.pop_front()));
    end
  end
  // Decoded values must come back near what was encoded
  always @(posedge mclk_i) begin
    if (dac_strobe_o === 1'b1) begin
      if (exp_dac.size() == 0) check(13'h0000, 13'h0001);
      else if (exp_dac[0] == NONE) void'(exp_dac.pop_front());
      else check(near(dac_sample_o, exp_dac.pop_front()), 13'h0001);
    end
  end
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(59));
    last = 8'h00;
    k = 0;
    c = 0;
    repeat (16) @(posedge mclk_i);
    srst_i <= 1'b0;
    r0 = cyc;
    @(posedge mclk_i);
    check(dac_sample_o, 13'h0000);
    check({12'h000, tx_serial_oe_n_o}, 13'h0001);
    for (int l = 0; l < 2; l++) begin
      for (int i = 0; i < 18; i++) period(l == 0, i < 10 ? 1 : 0);
      $display("law block %0d done", l);
    end
    period(1'b0, 2);
    for (int i = 0; i < 16; i++) period(1'b0, 3);
    check({12'h000, tx_overrun_o}, 13'h0000);
    wait_slot();
    // Queue full but the pending code is not lost until the next tick
    check({12'h000, tx_overrun_o}, 13'h0000);
    wait_slot();
    check({12'h000, tx_overrun_o}, 13'h0001);
    check({12'h000, oe_bad}, 13'h0000);
    check({12'h000, tx_serial_oe_n_o}, 13'h0001);
    check(13'(exp_dac.size() + exp_tx.size()), 13'h0000);
    $display("fifo and overrun test done");
    complete_run();
  end
endmodule // testbench
